// >>> pkg/bsc_pkg.sv
// Package for the branch and string control block
package bsc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_FLAGS = 6'h04;
  localparam logic [5:0] OFF_CS = 6'h08;
  localparam logic [5:0] OFF_IP = 6'h0c;
  localparam logic [5:0] OFF_CNT = 6'h10;
  localparam logic [5:0] OFF_SRC = 6'h14;
  localparam logic [5:0] OFF_DST = 6'h18;
  localparam logic [5:0] OFF_DISP = 6'h1c;
  localparam logic [5:0] OFF_STAT = 6'h20;
  localparam logic [5:0] OFF_FETCH = 6'h24;
  // Control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTRL_OP_LO = 4;
  localparam int CTRL_OP_HI = 8;
  localparam int CTRL_CC_LO = 12;
  localparam int CTRL_CC_HI = 15;
  localparam int CTRL_PFX_LO = 16;
  localparam int CTRL_PFX_HI = 17;
  localparam int CTRL_FAR = 18;
  // Flag register bit positions
  localparam int FL_CARRY = 0;
  localparam int FL_PARITY = 2;
  localparam int FL_ZERO = 6;
  localparam int FL_SIGN = 7;
  localparam int FL_DIR = 10;
  localparam int FL_OVF = 11;
  localparam logic [15:0] RESET_FLAGS = 16'h0000;
  localparam logic [15:0] RESET_CS = 16'hffff;
  localparam logic [15:0] RESET_IP = 16'h0000;
  localparam logic [4:0] OP_NONE = 5'h00;
  localparam logic [4:0] OP_JCC = 5'h01;
  localparam logic [4:0] OP_JMP = 5'h02;
  localparam logic [4:0] OP_CALL = 5'h03;
  localparam logic [4:0] OP_RET = 5'h04;
  localparam logic [4:0] OP_LOOP = 5'h05;
  localparam logic [4:0] OP_LOOPE = 5'h06;
  localparam logic [4:0] OP_LOOPNE = 5'h07;
  localparam logic [4:0] OP_JUMP_IF_COUNTER_ZERO = 5'h08;
  localparam logic [4:0] OP_STR_MOV = 5'h09;
  localparam logic [4:0] OP_STR_CMP = 5'h0a;
  localparam logic [4:0] OP_INT = 5'h0b;
  localparam logic [4:0] OP_INTERRUPT_ON_OVERFLOW = 5'h0c;
  localparam logic [4:0] OP_BOUND = 5'h0d;
  localparam logic [4:0] OP_INTERRUPT_RETURN = 5'h0e;
  localparam logic [1:0] PFX_NONE = 2'h0;
  localparam logic [1:0] PFX_REP = 2'h1;
  localparam logic [1:0] PFX_REPE = 2'h2;
  localparam logic [1:0] PFX_REPNE = 2'h3;
  // Condition codes, low bit negates
  localparam logic [3:0] CC_O = 4'h0;
  localparam logic [3:0] CC_C = 4'h2;
  localparam logic [3:0] CC_Z = 4'h4;
  localparam logic [3:0] CC_BE = 4'h6;
  localparam logic [3:0] CC_S = 4'h8;
  localparam logic [3:0] CC_P = 4'ha;
  localparam logic [3:0] CC_L = 4'hc;
  localparam logic [3:0] CC_LE = 4'he;
  localparam logic [1:0] STEP_BYTE = 2'h1;
  localparam logic [1:0] STEP_WORD = 2'h2;
  localparam logic [31:0] UNMAPPED = 32'h00000000;
  typedef struct packed {
    logic flush;
    logic soft_int;
    logic [15:0] cs;
    logic [15:0] ip;
  } bsc_fetch_t;
endpackage : bsc_pkg

// >>> rtl/bsc_core.sv
// Branch decision and repeated string control with Avalon-MM registers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Repeat prefix decrements the counter after every string repetition.
// - With a repeat prefix, counter zero at start skips the string operation entirely.
// - Direction flag clear steps indexes up, set steps them down.
// - Step is one for bytes and two for words.
// - Source offset from source index, destination offset from dest index.
// - Next fetch address is code segment base with instruction pointer.
// - Transfers flush the queue and fetch from the new location.
// - Calls, returns and jumps always redirect, near or far.
// - Conditional jump taken when true, else falls through.
// - Conditional jump target is signed byte displacement plus next address.
// - Unsigned conditions use carry and zero flags.
// - Signed conditions use sign xor overflow, with zero.
// - Single flag jumps test one flag, positive or negated.
// - Loops use the counter and reach only short targets.
// - Counter-zero jump branches when counter is zero.
// - Software interrupt, overflow, bounds and return instructions exist.
// - Software interrupts run no acknowledge bus cycle.
module bsc_core (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic i_bound_fail,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_flush,
  output logic o_soft_int,
  output logic o_int_ack,
  output logic [15:0] o_src_offset,
  output logic [15:0] o_dst_offset,
  output logic o_elem_strobe
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EXEC = 4'b0010,
    S_STR = 4'b0100,
    S_DONE = 4'b1000
  } bsc_state_t;

  bsc_state_t state;
  logic [31:0] ctrl;
  logic [15:0] flags;
  logic [15:0] code_seg;
  logic [15:0] instruction_pointer_reg;
  logic [15:0] repeat_counter_reg;
  logic [15:0] src_index_reg;
  logic [15:0] dest_index_reg;
  logic [15:0] disp;
  logic [15:0] far_seg;
  logic taken;
  logic [15:0] elems;
  logic served;
  bsc_pkg::bsc_fetch_t fetch;

  logic [4:0] op;
  logic [1:0] pfx;
  logic [3:0] cc;
  logic zero_flag;
  logic carry_flag;
  logic sign_flag;
  logic overflow_flag;
  logic parity_flag;
  logic direction_flag;
  logic cond_raw;
  logic cond;
  logic [15:0] step;
  logic [15:0] next_ip;
  logic [15:0] short_target;
  logic [15:0] cnt_dec;
  logic rep_stop;
  logic acc;
  logic elem_go;

  assign op = ctrl[bsc_pkg::CTRL_OP_HI:bsc_pkg::CTRL_OP_LO];
  assign pfx = ctrl[bsc_pkg::CTRL_PFX_HI:bsc_pkg::CTRL_PFX_LO];
  assign cc = ctrl[bsc_pkg::CTRL_CC_HI:bsc_pkg::CTRL_CC_LO];
  assign zero_flag = flags[bsc_pkg::FL_ZERO];
  assign carry_flag = flags[bsc_pkg::FL_CARRY];
  assign sign_flag = flags[bsc_pkg::FL_SIGN];
  assign overflow_flag = flags[bsc_pkg::FL_OVF];
  assign parity_flag = flags[bsc_pkg::FL_PARITY];
  assign direction_flag = flags[bsc_pkg::FL_DIR];
  assign cnt_dec = repeat_counter_reg - 16'h0001;
  assign acc = (i_read | i_write) & o_waitrequest;

  ////////////////////////////////////////////////////////////////////////
  // Condition evaluation
  always_comb begin
    case (cc[3:1])
      3'h0: cond_raw = overflow_flag;
      3'h1: cond_raw = carry_flag;
      3'h2: cond_raw = zero_flag;
      3'h3: cond_raw = carry_flag | zero_flag;
      3'h4: cond_raw = sign_flag;
      3'h5: cond_raw = parity_flag;
      3'h6: cond_raw = sign_flag ^ overflow_flag;
      3'h7: cond_raw = (sign_flag ^ overflow_flag) | zero_flag;
      default: cond_raw = 1'b0;
    endcase
  end
  assign cond = cond_raw ^ cc[0];

  assign step = ctrl[bsc_pkg::CTRL_WORD] ? {14'h0000, bsc_pkg::STEP_WORD}
                                         : {14'h0000, bsc_pkg::STEP_BYTE};
  // signed byte displacement from next instruction
  assign short_target = instruction_pointer_reg + {{8{disp[7]}}, disp[7:0]};
  // early end on zero flag mismatch
  assign rep_stop = (op == bsc_pkg::OP_STR_CMP) &&
                    (((pfx == bsc_pkg::PFX_REPE) && !zero_flag) ||
                     ((pfx == bsc_pkg::PFX_REPNE) && zero_flag));
  assign elem_go = (state == S_STR) &&
                   ((pfx == bsc_pkg::PFX_NONE) ||
                    (repeat_counter_reg != 16'h0000));

  always_comb begin
    taken = 1'b0;
    next_ip = instruction_pointer_reg;
    case (op)
      bsc_pkg::OP_JCC: taken = cond;
      bsc_pkg::OP_JMP, bsc_pkg::OP_CALL, bsc_pkg::OP_RET: taken = 1'b1;
      bsc_pkg::OP_LOOP: taken = (cnt_dec != 16'h0000);
      bsc_pkg::OP_LOOPE: taken = (cnt_dec != 16'h0000) && zero_flag;
      bsc_pkg::OP_LOOPNE: taken = (cnt_dec != 16'h0000) && !zero_flag;
      bsc_pkg::OP_JUMP_IF_COUNTER_ZERO: taken = (repeat_counter_reg == 16'h0000);
      bsc_pkg::OP_INT, bsc_pkg::OP_INTERRUPT_RETURN: taken = 1'b1;
      bsc_pkg::OP_INTERRUPT_ON_OVERFLOW: taken = overflow_flag;
      bsc_pkg::OP_BOUND: taken = i_bound_fail;
      default: taken = 1'b0;
    endcase
    if (taken) begin
      if (op == bsc_pkg::OP_JMP || op == bsc_pkg::OP_CALL ||
          op == bsc_pkg::OP_RET || op == bsc_pkg::OP_INT ||
          op == bsc_pkg::OP_INTERRUPT_ON_OVERFLOW || op == bsc_pkg::OP_BOUND ||
          op == bsc_pkg::OP_INTERRUPT_RETURN) begin
        next_ip = disp;
      end else begin
        next_ip = short_target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: if (ctrl[bsc_pkg::CTRL_GO]) begin
          state <= (op == bsc_pkg::OP_STR_MOV || op == bsc_pkg::OP_STR_CMP)
                   ? S_STR : S_EXEC;
        end
        S_EXEC: state <= S_DONE;
        S_STR: begin
          if (pfx == bsc_pkg::PFX_NONE) begin
            state <= S_DONE;
          end else if (repeat_counter_reg == 16'h0000) begin
            state <= S_DONE;
          // compare repeats stop after the element
          end else if (cnt_dec == 16'h0000 || rep_stop) begin
            state <= S_DONE;
          end
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Registers from bus and sequencer
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= 32'h00000000;
      flags <= bsc_pkg::RESET_FLAGS;
      code_seg <= bsc_pkg::RESET_CS;
      instruction_pointer_reg <= bsc_pkg::RESET_IP;
      repeat_counter_reg <= 16'h0000;
      src_index_reg <= 16'h0000;
      dest_index_reg <= 16'h0000;
      disp <= 16'h0000;
      far_seg <= 16'h0000;
      elems <= 16'h0000;
    end else begin
      if (acc && i_write) begin
        case (i_address)
          bsc_pkg::OFF_CTRL: ctrl <= i_writedata;
          bsc_pkg::OFF_FLAGS: flags <= i_writedata[15:0];
          bsc_pkg::OFF_CS: code_seg <= i_writedata[15:0];
          bsc_pkg::OFF_IP: instruction_pointer_reg <= i_writedata[15:0];
          bsc_pkg::OFF_CNT: repeat_counter_reg <= i_writedata[15:0];
          bsc_pkg::OFF_SRC: src_index_reg <= i_writedata[15:0];
          bsc_pkg::OFF_DST: dest_index_reg <= i_writedata[15:0];
          bsc_pkg::OFF_DISP: begin
            disp <= i_writedata[15:0];
            far_seg <= i_writedata[31:16];
          end
          default: ;
        endcase
      end
      if (state == S_IDLE && ctrl[bsc_pkg::CTRL_GO]) begin
        ctrl[bsc_pkg::CTRL_GO] <= 1'b0;
        elems <= 16'h0000;
      end
      if (state == S_EXEC) begin
        instruction_pointer_reg <= next_ip;
        // far forms load a new segment
        if (taken && ctrl[bsc_pkg::CTRL_FAR]) begin
          code_seg <= far_seg;
        end
        if (op == bsc_pkg::OP_LOOP || op == bsc_pkg::OP_LOOPE ||
            op == bsc_pkg::OP_LOOPNE) begin
          repeat_counter_reg <= cnt_dec;
        end
      end
      if (elem_go) begin
        elems <= elems + 16'h0001;
        if (direction_flag) begin
          src_index_reg <= src_index_reg - step;
          dest_index_reg <= dest_index_reg - step;
        end else begin
          src_index_reg <= src_index_reg + step;
          dest_index_reg <= dest_index_reg + step;
        end
        if (pfx != bsc_pkg::PFX_NONE) begin
          repeat_counter_reg <= cnt_dec;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch request toward the bus interface unit
  always_comb begin
    fetch.cs = code_seg;
    fetch.ip = next_ip;
    fetch.flush = (state == S_EXEC) && taken;
    fetch.soft_int = (state == S_EXEC) && taken &&
                     (op == bsc_pkg::OP_INT || op == bsc_pkg::OP_INTERRUPT_ON_OVERFLOW ||
                      op == bsc_pkg::OP_BOUND);
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flush <= 1'b0;
      o_soft_int <= 1'b0;
      o_int_ack <= 1'b0;
      o_elem_strobe <= 1'b0;
      o_src_offset <= 16'h0000;
      o_dst_offset <= 16'h0000;
      served <= 1'b0;
    end else begin
      o_flush <= fetch.flush;
      o_soft_int <= fetch.soft_int;
      // acknowledge never driven for software interrupts
      o_int_ack <= 1'b0;
      served <= fetch.flush;
      o_src_offset <= src_index_reg;
      o_dst_offset <= dest_index_reg;
      o_elem_strobe <= elem_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end else begin
      o_waitrequest <= !((i_read | i_write) && o_waitrequest);
      if (acc && i_read) begin
        case (i_address)
          bsc_pkg::OFF_CTRL: o_readdata <= ctrl;
          bsc_pkg::OFF_FLAGS: o_readdata <= {16'h0000, flags};
          bsc_pkg::OFF_CS: o_readdata <= {16'h0000, code_seg};
          bsc_pkg::OFF_IP: o_readdata <= {16'h0000, instruction_pointer_reg};
          bsc_pkg::OFF_CNT: o_readdata <= {16'h0000, repeat_counter_reg};
          bsc_pkg::OFF_SRC: o_readdata <= {16'h0000, src_index_reg};
          bsc_pkg::OFF_DST: o_readdata <= {16'h0000, dest_index_reg};
          bsc_pkg::OFF_DISP: o_readdata <= {far_seg, disp};
          bsc_pkg::OFF_STAT: o_readdata <= {elems, 11'h000, served,
                                            state};
          bsc_pkg::OFF_FETCH: o_readdata <= {code_seg,
                                             instruction_pointer_reg};
          default: o_readdata <= bsc_pkg::UNMAPPED;
        endcase
      end
    end
  end
endmodule : bsc_core
`default_nettype wire

// >>> bench/bsc_core_props.sv
// Port checker for the branch and string control block
`timescale 1ns/1ns
`default_nettype none
module bsc_core_props (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic o_flush,
  input wire logic o_soft_int,
  input wire logic o_int_ack,
  input wire logic [15:0] o_src_offset,
  input wire logic [15:0] o_dst_offset
);
  logic [3:0] since_wr;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  // Cycles since the last completed write, saturating
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_wr <= 4'hf;
    end else if (i_write && !o_waitrequest) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hf) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_taken;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("access not answered in one cycle");
  a_wait_idle: assert property (!(i_read || i_write) && o_waitrequest
    |=> o_waitrequest) else $error("answer without request");
  a_no_int_ack: assert property (!o_int_ack)
    else $error("acknowledge cycle seen");
  a_flush_pulse: assert property ($rose(o_flush) |=> !o_flush)
    else $error("flush longer than one cycle");
  a_flush_cause: assert property (o_flush |-> since_wr < 4'hf)
    else $error("flush without a command");
  a_soft_pulse: assert property ($rose(o_soft_int) |=> !o_soft_int)
    else $error("soft interrupt longer than one cycle");
  a_soft_cause: assert property (o_soft_int |-> since_wr < 4'hf)
    else $error("soft interrupt without a command");
  a_index_step: assert property (
    $changed(o_src_offset) && $changed(o_dst_offset)
    |-> (o_src_offset - $past(o_src_offset))
      == (o_dst_offset - $past(o_dst_offset))
    && ((o_src_offset - $past(o_src_offset))
      inside {16'h1, 16'h2, 16'hffff, 16'hfffe}))
    else $error("index step wrong");
endmodule : bsc_core_props
bind bsc_core bsc_core_props u_bsc_core_props (.i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .o_flush(o_flush),
  .o_soft_int(o_soft_int), .o_int_ack(o_int_ack),
  .o_src_offset(o_src_offset), .o_dst_offset(o_dst_offset));
`default_nettype wire

// >>> bench/bsc_biu_model.sv
// Fetch-side model counting queue flushes and soft interrupts
`timescale 1ns/1ns
`default_nettype none
module bsc_biu_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_soft_int,
  input wire logic i_bound_bad,
  output logic o_bound_fail,
  output logic [7:0] o_flushes,
  output logic [7:0] o_ints
);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flushes <= 8'h00;
      o_ints <= 8'h00;
    end else begin
      o_flushes <= o_flushes + {7'h00, i_flush};
      o_ints <= o_ints + {7'h00, i_soft_int};
    end
  end
  assign o_bound_fail = i_bound_bad;
endmodule : bsc_biu_model
`default_nettype wire

// >>> bench/bsc_core_tb_top.sv
// Self-checking bench for the branch and string control block
`timescale 1ns/1ns
`default_nettype none
module bsc_core_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic bad = 1'b0;
  logic bfail;
  logic [31:0] rdata;
  logic waitreq;
  logic flush;
  logic sint;
  logic iack;
  logic [15:0] srco;
  logic [15:0] dsto;
  logic estb;
  logic [7:0] nstb;
  logic [7:0] flushes;
  logic [7:0] ints;
  int miscompares = 0;
  int num_checks = 0;
  // Loop table: op, count, zero, count after, taken
  logic [31:0] lt [8] = '{32'h05_02_0_01_1, 32'h05_01_0_00_0,
    32'h06_03_0_02_0, 32'h06_03_1_02_1, 32'h07_03_1_02_0,
    32'h07_03_0_02_1, 32'h08_00_0_00_1, 32'h08_05_0_05_0};
  // String table: op, prefix, word, direction, count, zero
  logic [31:0] st [6] = '{32'h09_1_1_1_03_0, 32'h09_1_0_0_00_0,
    32'h0a_2_0_0_05_0, 32'h0a_3_1_0_05_1, 32'h0a_2_0_0_02_1,
    32'h09_0_0_1_05_0};
  // Interrupt table: op, overflow, bound bad, expected count step
  logic [15:0] it [6] = '{16'hb001, 16'hc000, 16'hc101, 16'hd000,
    16'hd011, 16'he000};
  always #10 clk = ~clk;
  bsc_core u_bsc_core (.i_ref_clk(clk), .i_resetn(rstn), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hf),
    .i_bound_fail(bfail), .o_readdata(rdata), .o_waitrequest(waitreq),
    .o_flush(flush), .o_soft_int(sint), .o_int_ack(iack),
    .o_src_offset(srco), .o_dst_offset(dsto), .o_elem_strobe(estb));
  bsc_biu_model u_bsc_biu_model (.i_ref_clk(clk), .i_resetn(rstn),
    .i_flush(flush), .i_soft_int(sint), .i_bound_bad(bad),
    .o_bound_fail(bfail), .o_flushes(flushes), .o_ints(ints));
  // Element strobes seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nstb <= 8'h00;
    end else begin
      nstb <= nstb + {7'h00, estb};
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : cmp
  task automatic access(logic w, logic [5:0] a, logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 200);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (n >= 200) begin
      miscompares++;
      conclude();
    end
  endtask : access
  task automatic wreg(logic [5:0] a, logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(string nm, logic [5:0] a, logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    cmp(nm, e, q);
  endtask : rchk
  task automatic run(logic [31:0] c);
    logic [31:0] q;
    int n;
    wreg(bsc_pkg::OFF_CTRL, c | 32'h1);
    n = 0;
    do begin
      access(1'b0, bsc_pkg::OFF_STAT, 32'h0, q);
      n++;
    end while (q[3:0] !== 4'h1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      conclude();
    end
  endtask : run
  function automatic logic [31:0] ctl(logic [4:0] op, logic [3:0] cc,
    logic [1:0] pf, logic w, logic f);
    return {13'h0, f, pf, cc, 3'h0, op, 2'h0, w, 1'b0};
  endfunction : ctl
  function automatic logic cond(logic [3:0] cc, logic [15:0] f);
    logic z;
    logic s;
    logic o;
    logic r;
    z = f[bsc_pkg::FL_ZERO];
    s = f[bsc_pkg::FL_SIGN];
    o = f[bsc_pkg::FL_OVF];
    case (cc[3:1])
      3'h0: r = o;
      3'h1: r = f[bsc_pkg::FL_CARRY];
      3'h2: r = z;
      3'h3: r = f[bsc_pkg::FL_CARRY] | z;
      3'h4: r = s;
      3'h5: r = f[bsc_pkg::FL_PARITY];
      3'h6: r = s ^ o;
      default: r = (s ^ o) | z;
    endcase
    return r ^ cc[0];
  endfunction : cond
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] e;
    logic [15:0] fl;
    logic [15:0] d;
    logic [7:0] n;
    logic [7:0] nf;
    logic [7:0] ni;
    logic [7:0] ne;
    logic [15:0] es;
    logic [15:0] ed;
    nf = 8'h00;
    ni = 8'h00;
    ne = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rchk("flags", bsc_pkg::OFF_FLAGS, 32'h0);
    rchk("fetch", bsc_pkg::OFF_FETCH, {bsc_pkg::RESET_CS, 16'h0});
    rchk("unmapped", 6'h3c, bsc_pkg::UNMAPPED);
    $display("test reset done");
    for (int k = 0; k < 32; k++) begin
      fl = k[4] ? 16'h0884 : 16'h0841;
      wreg(bsc_pkg::OFF_FLAGS, {16'h0, fl});
      wreg(bsc_pkg::OFF_IP, 32'h100);
      wreg(bsc_pkg::OFF_DISP, k[4] ? 32'h7f : 32'h80);
      run(ctl(bsc_pkg::OP_JCC, k[3:0], bsc_pkg::PFX_NONE, 1'b0, 1'b0));
      nf = nf + {7'h0, cond(k[3:0], fl)};
      e = k[4] ? 32'h17f : 32'h080;
      rchk("jcc ip", bsc_pkg::OFF_IP,
        cond(k[3:0], fl) ? e : 32'h100);
    end
    $display("test jcc done");
    wreg(bsc_pkg::OFF_DISP, 32'h1234_5678);
    run(ctl(bsc_pkg::OP_JMP, 4'h0, bsc_pkg::PFX_NONE, 1'b0, 1'b1));
    rchk("far jmp", bsc_pkg::OFF_FETCH, 32'h1234_5678);
    for (int k = 0; k < 3; k++) begin
      wreg(bsc_pkg::OFF_DISP, 32'h40 + k);
      run(ctl(k == 2 ? bsc_pkg::OP_JMP : bsc_pkg::OP_CALL + 5'(k), 4'h0,
        bsc_pkg::PFX_NONE, 1'b0, 1'b0));
      rchk("near", bsc_pkg::OFF_FETCH, 32'h1234_0040 + k);
    end
    nf = nf + 8'h4;
    wreg(bsc_pkg::OFF_DISP, 32'h10);
    foreach (lt[i]) begin
      wreg(bsc_pkg::OFF_FLAGS, 32'(lt[i][12]) << bsc_pkg::FL_ZERO);
      wreg(bsc_pkg::OFF_CNT, {24'h0, lt[i][23:16]});
      wreg(bsc_pkg::OFF_IP, 32'h200);
      run(ctl(lt[i][28:24], 4'h0, bsc_pkg::PFX_NONE, 1'b0, 1'b0));
      nf = nf + {7'h0, lt[i][0]};
      rchk("loop cnt", bsc_pkg::OFF_CNT,
        {24'h0, lt[i][11:4]});
      rchk("loop ip", bsc_pkg::OFF_IP,
        lt[i][0] ? 32'h210 : 32'h200);
    end
    cmp("flushes", {24'h0, nf}, {24'h0, flushes});
    $display("test transfer done");
    foreach (st[i]) begin
      e = st[i];
      wreg(bsc_pkg::OFF_FLAGS, (32'(e[12]) << bsc_pkg::FL_DIR)
        | (32'(e[0]) << bsc_pkg::FL_ZERO));
      wreg(bsc_pkg::OFF_CNT, {24'h0, e[11:4]});
      wreg(bsc_pkg::OFF_SRC, 32'h100);
      wreg(bsc_pkg::OFF_DST, 32'h200);
      run(ctl(e[28:24], 4'h0, e[21:20], e[16], 1'b0));
      n = (e[23:20] == 4'h0) ? 8'h1 : (e[11:4] == 8'h0) ? 8'h0
        : (e[28:24] == bsc_pkg::OP_STR_CMP
        && (e[0] ^ (e[21:20] == bsc_pkg::PFX_REPE))) ? 8'h1 : e[11:4];
      d = {8'h0, n} << e[16];
      es = e[12] ? 16'h100 - d : 16'h100 + d;
      ed = e[12] ? 16'h200 - d : 16'h200 + d;
      rchk("str cnt", bsc_pkg::OFF_CNT,
        {24'h0, (e[23:20] == 4'h0) ? e[11:4] : e[11:4] - n});
      rchk("str src", bsc_pkg::OFF_SRC, {16'h0, es});
      rchk("str dst", bsc_pkg::OFF_DST, {16'h0, ed});
      cmp("src out", {16'h0, es}, {16'h0, srco});
      cmp("dst out", {16'h0, ed}, {16'h0, dsto});
      rchk("str elems", bsc_pkg::OFF_STAT, {8'h0, n, 16'h0001});
      ne = ne + n;
    end
    cmp("strobes", {24'h0, ne}, {24'h0, nstb});
    $display("test string done");
    foreach (it[i]) begin
      wreg(bsc_pkg::OFF_FLAGS, 32'(it[i][8]) << bsc_pkg::FL_OVF);
      bad <= it[i][4];
      run(ctl({1'b0, it[i][15:12]}, 4'h0, bsc_pkg::PFX_NONE, 1'b0, 1'b0));
      ni = ni + {7'h0, it[i][0]};
      cmp("soft ints", {24'h0, ni}, {24'h0, ints});
    end
    cmp("int ack", 32'h0, {31'h0, iack});
    $display("test interrupt done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rchk("fetch rst", bsc_pkg::OFF_FETCH, {bsc_pkg::RESET_CS, 16'h0});
    $display("test reset again done");
    conclude();
  end
endmodule : bsc_core_tb_top
`default_nettype wire
